// File: src/aotc_pkg.sv
// aotc_pkg: constants and types for the converter output test/config bank
// assumes 8-bit register addresses and 12-bit sample words
package aotc_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] TEST_SEL_ADDR   = 8'h0D;
    localparam logic [7:0] OFFSET_ADDR     = 8'h10;
    localparam logic [7:0] FORMAT_ADDR     = 8'h14;
    localparam logic [7:0] DRIVE_ADDR      = 8'h15;
    localparam logic [7:0] CLK_PHASE_ADDR  = 8'h16;
    localparam logic [7:0] CLK_DELAY_ADDR  = 8'h17;
    localparam logic [7:0] SPAN_ADDR       = 8'h18;

    // ==========================================================
    // reset values
    localparam logic [7:0] TEST_SEL_RST    = 8'h00;
    localparam logic [7:0] OFFSET_RST      = 8'h00;
    localparam logic [7:0] FORMAT_RST      = 8'h05;
    localparam logic [7:0] DRIVE_RST       = 8'h01;
    localparam logic [7:0] CLK_PHASE_RST   = 8'h00;
    localparam logic [7:0] CLK_DELAY_RST   = 8'h00;
    localparam logic [7:0] SPAN_RST        = 8'h00;

    // ==========================================================
    // implemented bits; open bits read as zero
    localparam logic [7:0] TEST_SEL_MASK   = 8'hBF;
    localparam logic [7:0] OFFSET_MASK     = 8'h3F;
    localparam logic [7:0] FORMAT_MASK     = 8'h17;
    localparam logic [7:0] DRIVE_MASK      = 8'h0F;
    localparam logic [7:0] CLK_PHASE_MASK  = 8'hA0;
    localparam logic [7:0] CLK_DELAY_MASK  = 8'h9F;
    localparam logic [7:0] SPAN_MASK       = 8'h1F;

    // ==========================================================
    // field positions
    localparam int USER_SINGLE_BIT  = 7;
    localparam int PN_LONG_RST_BIT  = 5;
    localparam int PN_SHORT_RST_BIT = 4;
    localparam int OUT_DISABLE_BIT  = 4;
    localparam int OUT_NORMAL_BIT   = 2;
    localparam int CLK_INVERT_BIT   = 7;
    localparam int ODD_EVEN_BIT     = 5;
    localparam int DELAY_EN_BIT     = 7;

    // ==========================================================
    // sample width and pattern words (offset binary)
    localparam int DATA_W = 12;
    localparam logic [11:0] MIDSCALE_CODE = 12'h800;
    localparam logic [11:0] POS_FS_CODE   = 12'hFFF;
    localparam logic [11:0] NEG_FS_CODE   = 12'h000;
    localparam logic [11:0] CHECKER_A     = 12'hAAA;
    localparam logic [11:0] CHECKER_B     = 12'h555;
    localparam logic [11:0] ALL_ONES      = 12'hFFF;
    localparam logic [11:0] ALL_ZEROS     = 12'h000;
    localparam logic [11:0] SAT_MAX       = 12'hFFF;
    localparam logic [11:0] SAT_MIN       = 12'h000;

    // pseudo-random generators: length and feedback tap
    localparam int PN_LONG_W   = 23;
    localparam int PN_LONG_TAP = 18;
    localparam int PN_SHORT_W  = 9;
    localparam int PN_SHORT_TAP = 5;
    localparam int USER_WORDS  = 4;

    typedef enum logic [3:0] {
        TEST_OFF      = 4'b0000,
        TEST_MIDSCALE = 4'b0001,
        TEST_POS_FS   = 4'b0010,
        TEST_NEG_FS   = 4'b0011,
        TEST_CHECKER  = 4'b0100,
        TEST_PN_LONG  = 4'b0101,
        TEST_PN_SHORT = 4'b0110,
        TEST_TOGGLE   = 4'b0111,
        TEST_USER     = 4'b1000,
        TEST_RAMP     = 4'b1111
    } aotc_test_type;

    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'b00,
        FMT_TWOS_COMP  = 2'b01,
        FMT_GRAY       = 2'b10,
        FMT_RESERVED   = 2'b11
    } aotc_format_type;

    // register write request from the serial control port
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } aotc_wreq_type;

    // four user pattern words, 16 bits each, MSB-aligned data
    typedef struct packed {
        logic [15:0] word3;
        logic [15:0] word2;
        logic [15:0] word1;
        logic [15:0] word0;
    } aotc_user_type;

endpackage

// File: src/aotc_top.sv
// aotc_top: output test/config register bank with test pattern generator
// assumes the serial port deframes writes into one-cycle requests on CLK,
// and samples arrive as offset binary words on CLK
`timescale 1ns/1ps
module aotc_top (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST,
    // register access from the serial control port
    input  wire aotc_pkg::aotc_wreq_type WREQ,
    input  wire logic [7:0]            RD_ADDR,
    output logic      [7:0]            RD_DATA,
    // user pattern words held outside this bank
    input  wire aotc_pkg::aotc_user_type USER_PAT,
    // converted samples and formatted output
    input  wire logic [11:0]           SAMPLE,
    output logic      [11:0]           DATA_OUT,
    output logic                       DATA_OE,
    // settings for the analog and clock output stages
    output logic      [3:0]            DRIVE_CODE,
    output logic      [4:0]            SPAN_CODE,
    output logic                       OUT_CLK_INVERT,
    output logic                       ODD_EVEN_EN,
    output logic                       OUT_CLK_DELAY_EN,
    output logic      [4:0]            OUT_CLK_DELAY
);

    // ==========================================================
    // register file
    logic [7:0] test_reg, offset_reg, format_reg, drive_reg;
    logic [7:0] phase_reg, delay_reg, span_reg;

    wire logic wr_test   = WREQ.wr && WREQ.addr == aotc_pkg::TEST_SEL_ADDR;
    wire logic wr_offset = WREQ.wr && WREQ.addr == aotc_pkg::OFFSET_ADDR;
    wire logic wr_format = WREQ.wr && WREQ.addr == aotc_pkg::FORMAT_ADDR;
    wire logic wr_drive  = WREQ.wr && WREQ.addr == aotc_pkg::DRIVE_ADDR;
    wire logic wr_phase  = WREQ.wr && WREQ.addr == aotc_pkg::CLK_PHASE_ADDR;
    wire logic wr_delay  = WREQ.wr && WREQ.addr == aotc_pkg::CLK_DELAY_ADDR;
    wire logic wr_span   = WREQ.wr && WREQ.addr == aotc_pkg::SPAN_ADDR;

    always_ff @(posedge CLK) begin
        if (RST) begin
            test_reg   <= aotc_pkg::TEST_SEL_RST;
            offset_reg <= aotc_pkg::OFFSET_RST;
            format_reg <= aotc_pkg::FORMAT_RST;
            drive_reg  <= aotc_pkg::DRIVE_RST;
            phase_reg  <= aotc_pkg::CLK_PHASE_RST;
            delay_reg  <= aotc_pkg::CLK_DELAY_RST;
            span_reg   <= aotc_pkg::SPAN_RST;
        end else begin
            if (wr_test)   test_reg   <= WREQ.data & aotc_pkg::TEST_SEL_MASK;
            if (wr_offset) offset_reg <= WREQ.data & aotc_pkg::OFFSET_MASK;
            if (wr_format) format_reg <= WREQ.data & aotc_pkg::FORMAT_MASK;
            if (wr_drive)  drive_reg  <= WREQ.data & aotc_pkg::DRIVE_MASK;
            if (wr_phase)  phase_reg  <= WREQ.data & aotc_pkg::CLK_PHASE_MASK;
            if (wr_delay)  delay_reg  <= WREQ.data & aotc_pkg::CLK_DELAY_MASK;
            if (wr_span)   span_reg   <= WREQ.data & aotc_pkg::SPAN_MASK;
        end
    end

    // ==========================================================
    // read back
    logic [7:0] rd_next;
    always_comb begin
        unique case (RD_ADDR)
            aotc_pkg::TEST_SEL_ADDR:  rd_next = test_reg;
            aotc_pkg::OFFSET_ADDR:    rd_next = offset_reg;
            aotc_pkg::FORMAT_ADDR:    rd_next = format_reg;
            aotc_pkg::DRIVE_ADDR:     rd_next = drive_reg;
            aotc_pkg::CLK_PHASE_ADDR: rd_next = phase_reg;
            aotc_pkg::CLK_DELAY_ADDR: rd_next = delay_reg;
            aotc_pkg::SPAN_ADDR:      rd_next = span_reg;
            default:                  rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) RD_DATA <= 8'h00;
        else     RD_DATA <= rd_next;
    end

    // ==========================================================
    // pattern sources
    wire logic [3:0] test_code = test_reg[3:0];
    wire logic user_single = test_reg[aotc_pkg::USER_SINGLE_BIT];
    wire logic pn_long_hold = test_reg[aotc_pkg::PN_LONG_RST_BIT];
    wire logic pn_short_hold = test_reg[aotc_pkg::PN_SHORT_RST_BIT];

    logic [aotc_pkg::PN_LONG_W-1:0]  pn_long_reg;
    logic [aotc_pkg::PN_SHORT_W-1:0] pn_short_reg;
    logic [11:0] ramp_reg;
    logic        phase_bit_reg;
    logic [1:0]  user_idx_reg;
    logic        user_done_reg;

    wire logic pn_long_fb = pn_long_reg[aotc_pkg::PN_LONG_W-1]
                          ^ pn_long_reg[aotc_pkg::PN_LONG_TAP-1];
    wire logic pn_short_fb = pn_short_reg[aotc_pkg::PN_SHORT_W-1]
                           ^ pn_short_reg[aotc_pkg::PN_SHORT_TAP-1];
    wire logic user_last = user_idx_reg == 2'(aotc_pkg::USER_WORDS - 1);

    always_ff @(posedge CLK) begin
        if (RST || pn_long_hold) pn_long_reg <= '1;
        else pn_long_reg <= {pn_long_reg[aotc_pkg::PN_LONG_W-2:0], pn_long_fb};
    end

    always_ff @(posedge CLK) begin
        if (RST || pn_short_hold) pn_short_reg <= '1;
        else pn_short_reg <= {pn_short_reg[aotc_pkg::PN_SHORT_W-2:0],
                              pn_short_fb};
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ramp_reg      <= 12'h000;
            phase_bit_reg <= 1'b0;
        end else begin
            ramp_reg      <= ramp_reg + 12'h001;
            phase_bit_reg <= ~phase_bit_reg;
        end
    end

    // user words cycle; single mode parks at zeros until test select rewritten
    always_ff @(posedge CLK) begin
        if (RST || wr_test) begin
            user_idx_reg  <= 2'h0;
            user_done_reg <= 1'b0;
        end else if (test_code == aotc_pkg::TEST_USER) begin
            user_idx_reg <= user_idx_reg + 2'h1;
            if (user_last && user_single) user_done_reg <= 1'b1;
        end
    end

    logic [15:0] user_word;
    always_comb begin
        unique case (user_idx_reg)
            2'h0: user_word = USER_PAT.word0;
            2'h1: user_word = USER_PAT.word1;
            2'h2: user_word = USER_PAT.word2;
            2'h3: user_word = USER_PAT.word3;
        endcase
    end

    // ==========================================================
    // pattern select
    logic [11:0] test_word;
    always_comb begin
        unique case (test_code)
            aotc_pkg::TEST_MIDSCALE: test_word = aotc_pkg::MIDSCALE_CODE;
            aotc_pkg::TEST_POS_FS:   test_word = aotc_pkg::POS_FS_CODE;
            aotc_pkg::TEST_NEG_FS:   test_word = aotc_pkg::NEG_FS_CODE;
            aotc_pkg::TEST_CHECKER:  test_word = phase_bit_reg ?
                aotc_pkg::CHECKER_B : aotc_pkg::CHECKER_A;
            aotc_pkg::TEST_PN_LONG:  test_word = pn_long_reg[11:0];
            aotc_pkg::TEST_PN_SHORT:
                test_word = {pn_short_reg, pn_short_reg[8:6]};
            aotc_pkg::TEST_TOGGLE:   test_word = phase_bit_reg ?
                aotc_pkg::ALL_ZEROS : aotc_pkg::ALL_ONES;
            aotc_pkg::TEST_USER:     test_word = user_done_reg ?
                aotc_pkg::ALL_ZEROS : user_word[15:4];
            aotc_pkg::TEST_RAMP:     test_word = ramp_reg;
            default:                 test_word = aotc_pkg::ALL_ZEROS;
        endcase
    end

    // ==========================================================
    // offset trim with saturation on live samples
    wire logic [12:0] trim_sum = {1'b0, SAMPLE}
                               + {{7{offset_reg[5]}}, offset_reg[5:0]};
    wire logic trim_neg = offset_reg[5];
    // bit 12 is a carry for a positive trim, a borrow for a negative one
    wire logic [11:0] trimmed = !trim_sum[12] ? trim_sum[11:0]
                              : (trim_neg ? aotc_pkg::SAT_MIN
                                          : aotc_pkg::SAT_MAX);
    wire logic [11:0] sample_trim = trimmed;

    // ==========================================================
    // source mux and output format
    wire logic test_on = test_code != aotc_pkg::TEST_OFF;
    wire logic [11:0] src_word = test_on ? test_word : sample_trim;

    logic [11:0] fmt_word;
    always_comb begin
        unique case (format_reg[1:0])
            aotc_pkg::FMT_TWOS_COMP:  fmt_word = src_word ^ 12'h800;
            aotc_pkg::FMT_GRAY:       fmt_word = src_word ^ (src_word >> 1);
            aotc_pkg::FMT_OFFSET_BIN: fmt_word = src_word;
            aotc_pkg::FMT_RESERVED:   fmt_word = src_word;
        endcase
    end

    wire logic out_normal = format_reg[aotc_pkg::OUT_NORMAL_BIT];
    wire logic [11:0] data_next = out_normal ? fmt_word : ~fmt_word;

    always_ff @(posedge CLK) begin
        if (RST) begin
            DATA_OUT <= 12'h000;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OUT <= data_next;
            DATA_OE  <= ~format_reg[aotc_pkg::OUT_DISABLE_BIT];
        end
    end

    // ==========================================================
    // stage settings straight from register flops
    assign DRIVE_CODE       = drive_reg[3:0];
    assign SPAN_CODE        = span_reg[4:0];
    assign OUT_CLK_INVERT   = phase_reg[aotc_pkg::CLK_INVERT_BIT];
    assign ODD_EVEN_EN      = phase_reg[aotc_pkg::ODD_EVEN_BIT];
    assign OUT_CLK_DELAY_EN = delay_reg[aotc_pkg::DELAY_EN_BIT];
    assign OUT_CLK_DELAY    = delay_reg[4:0];

endmodule

// File: testbench/aotc_top_assertions.sv
// aotc_top_assertions: port checks for the output test/config bank
// assumes binding to aotc_top; shadows track the data path registers
`timescale 1ns/1ps
module aotc_top_assertions (
    // clock and reset
    input wire logic                    CLK,
    input wire logic                    RST,
    // register writes and data path
    input wire aotc_pkg::aotc_wreq_type WREQ,
    input wire logic [11:0]             SAMPLE,
    input wire logic [11:0]             DATA_OUT,
    input wire logic                    DATA_OE,
    // stage settings
    input wire logic [3:0]              DRIVE_CODE,
    input wire logic [4:0]              SPAN_CODE
);
    // ==========================================================
    // shadow registers
    logic [7:0] ts_q;
    logic [7:0] fm_q;
    logic [7:0] off_q;
    wire hit_drv = WREQ.wr && WREQ.addr == aotc_pkg::DRIVE_ADDR;
    wire hit_spn = WREQ.wr && WREQ.addr == aotc_pkg::SPAN_ADDR;
    wire ob = !RST && {fm_q[4], fm_q[2:0]} == 4'b0100;
    wire raw = !RST && ts_q[3:0] == 4'h0 && off_q[5:0] == 6'h00
               && {fm_q[4], fm_q[2]} == 2'b01;
    wire ck = ob && ts_q[3:0] == 4'h4;
    wire tg = ob && ts_q[3:0] == 4'h7;
    wire rp = ob && ts_q[3:0] == 4'hF;
    always_ff @(posedge CLK) begin
        if (RST) begin
            ts_q <= 8'h00;
            fm_q <= 8'h05;
            off_q <= 8'h00;
        end else if (WREQ.wr) begin
            if (WREQ.addr == aotc_pkg::TEST_SEL_ADDR) ts_q <= WREQ.data;
            if (WREQ.addr == aotc_pkg::FORMAT_ADDR) fm_q <= WREQ.data;
            if (WREQ.addr == aotc_pkg::OFFSET_ADDR) off_q <= WREQ.data;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_drive_write: assert property (hit_drv
        |=> DRIVE_CODE == $past(WREQ.data[3:0])) else $error("drive code");
    chk_span_write: assert property (hit_spn
        |=> SPAN_CODE == $past(WREQ.data[4:0])) else $error("span code");
    chk_midscale_code: assert property ($past(ob && ts_q[3:0] == 4'h1)
        |-> DATA_OUT == 12'h800) else $error("midscale word");
    chk_checker_word: assert property ($past(ck) && $past(ck, 2)
        |-> DATA_OUT inside {12'hAAA, 12'h555} && DATA_OUT == ~$past(DATA_OUT))
        else $error("checkerboard word");
    chk_toggle_word: assert property ($past(tg) && $past(tg, 2)
        |-> DATA_OUT inside {12'hFFF, 12'h000} && DATA_OUT == ~$past(DATA_OUT))
        else $error("toggle word");
    chk_ramp_step: assert property ($past(rp) && $past(rp, 2)
        |-> DATA_OUT == $past(DATA_OUT) + 12'h001) else $error("ramp step");
    chk_pass_binary: assert property ($past(raw && fm_q[1:0] == 2'b00)
        |-> DATA_OUT == $past(SAMPLE)) else $error("offset binary");
    chk_pass_twos: assert property ($past(raw && fm_q[1:0] == 2'b01)
        |-> DATA_OUT == ($past(SAMPLE) ^ 12'h800)) else $error("twos comp");
    chk_pass_gray: assert property ($past(raw && fm_q[1:0] == 2'b10)
        |-> DATA_OUT == ($past(SAMPLE) ^ ($past(SAMPLE) >> 1)))
        else $error("gray code");
    chk_oe_follow: assert property (!$past(RST)
        |-> DATA_OE == !$past(fm_q[4])) else $error("output enable");
    cov_ramp: cover property ($past(rp) && rp);
    cov_checker: cover property ($past(ck) && ck);
    cov_oe_off: cover property ($fell(DATA_OE));
endmodule

bind aotc_top aotc_top_assertions i_aotc_top_assertions (
    .CLK(CLK), .RST(RST), .WREQ(WREQ), .SAMPLE(SAMPLE),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .DRIVE_CODE(DRIVE_CODE),
    .SPAN_CODE(SPAN_CODE));

// File: testbench/aotc_top_tb_top.sv
// aotc_top_tb_top: register and data path tests for the output bank
// assumes the package, aotc_top and its checker are compiled first
`timescale 1ns/1ps
module aotc_top_tb_top;
    // ==========================================================
    // signals and tables
    logic                    clk;
    logic                    rst;
    aotc_pkg::aotc_wreq_type wreq;
    logic [7:0]              rd_addr;
    logic [7:0]              rd_data;
    aotc_pkg::aotc_user_type user_pat;
    logic [11:0]             sample;
    logic [11:0]             data_out;
    logic                    data_oe;
    logic [3:0]              drive_code;
    logic [4:0]              span_code;
    logic                    clk_inv;
    logic                    odd_even;
    logic                    dly_en;
    logic [4:0]              dly;
    logic [11:0]             prev;
    int                      failures;
    int                      cmp_count;
    logic [7:0] adr [7] = '{8'h0D, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [7] = '{8'hBF, 8'h3F, 8'h17, 8'h0F, 8'hA0, 8'h9F, 8'h1F};

    aotc_top i_aotc_top (
        .CLK(clk), .RST(rst), .WREQ(wreq), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .USER_PAT(user_pat), .SAMPLE(sample),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .DRIVE_CODE(drive_code),
        .SPAN_CODE(span_code), .OUT_CLK_INVERT(clk_inv),
        .ODD_EVEN_EN(odd_even), .OUT_CLK_DELAY_EN(dly_en),
        .OUT_CLK_DELAY(dly));

    // ==========================================================
    // access and compare tasks
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [11:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        wreq = '{1'b1, a, d};
        @(negedge clk);
        wreq.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk);
        rd_addr = a;
        @(negedge clk);
        cmp("rd_data", {4'h0, e}, {4'h0, rd_data});
    endtask
    task automatic dout(input logic [11:0] e);
        @(negedge clk);
        cmp("data_out", e, data_out);
    endtask
    task automatic fmt(input logic [7:0] f, o, input logic [11:0] s, e);
        wr(8'h14, f);
        wr(8'h10, o);
        sample = s;
        dout(e);
    endtask
    task automatic pat(input logic [7:0] code, input logic [11:0] e);
        wr(8'h0D, code);
        dout(e);
    endtask
    // a word of 001 marks the ramp, which counts instead of toggling
    task automatic step(input logic [7:0] code, input logic [11:0] w);
        wr(8'h0D, code);
        @(negedge clk);
        prev = data_out;
        @(negedge clk);
        if (w != 12'h001) cmp("pat_word", (prev == w) ? w : ~w, prev);
        cmp("pat_next", (w == 12'h001) ? prev + w : ~prev, data_out);
    endtask

    // ==========================================================
    // clock, watchdog and test sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        wreq = '0;
        rd_addr = 8'h00;
        sample = 12'h123;
        user_pat = {16'h4440, 16'h3330, 16'h2220, 16'h1110};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) rd(adr[i], rv[i]);
        for (int i = 0; i < 7; i++) begin
            wr(adr[i], 8'hFF);
            rd(adr[i], msk[i]);
            wr(adr[i], rv[i]);
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        wr(8'h15, 8'h00);
        cmp("drive_code", 12'h000, {8'h00, drive_code});
        wr(8'h15, 8'h0F);
        cmp("drive_code", 12'h00F, {8'h00, drive_code});
        wr(8'h18, 8'h10);
        cmp("span_code", 12'h010, {7'h00, span_code});
        wr(8'h18, 8'h0F);
        cmp("span_code", 12'h00F, {7'h00, span_code});
        wr(8'h16, 8'hA0);
        cmp("out_clk_invert", 12'h001, {11'h000, clk_inv});
        cmp("odd_even_en", 12'h001, {11'h000, odd_even});
        wr(8'h17, 8'h9F);
        cmp("out_clk_delay_en", 12'h001, {11'h000, dly_en});
        cmp("out_clk_delay", 12'h01F, {7'h00, dly});
        fmt(8'h05, 8'h00, 12'h123, 12'h923);
        fmt(8'h04, 8'h00, 12'h123, 12'h123);
        fmt(8'h06, 8'h00, 12'h123, 12'h123 ^ 12'h091);
        fmt(8'h04, 8'h3F, 12'h123, 12'h122);
        fmt(8'h04, 8'h3F, 12'h000, 12'h000);
        fmt(8'h04, 8'h1F, 12'hFF0, 12'hFFF);
        fmt(8'h14, 8'h00, 12'h123, 12'h123);
        cmp("data_oe", 12'h000, {11'h000, data_oe});
        fmt(8'h04, 8'h00, 12'h123, 12'h123);
        cmp("data_oe", 12'h001, {11'h000, data_oe});
        pat(8'h01, 12'h800);
        pat(8'h02, 12'hFFF);
        pat(8'h03, 12'h000);
        pat(8'h09, 12'h000);
        wr(8'h0D, 8'h20);
        pat(8'h25, 12'hFFF);
        dout(12'hFFF);
        wr(8'h0D, 8'h10);
        pat(8'h16, 12'hFFF);
        dout(12'hFFF);
        for (int c = 5; c < 7; c++) begin
            wr(8'h0D, 8'(c));
            @(negedge clk);
            prev = data_out;
            @(negedge clk);
            cmp("pn_moves", 12'h001, {11'h000, data_out !== prev});
        end
        step(8'h04, 12'hAAA);
        step(8'h07, 12'hFFF);
        step(8'h0F, 12'h001);
        for (int m = 0; m < 2; m++) begin
            wr(8'h0D, (m == 1) ? 8'h88 : 8'h08);
            for (int k = 1; k < 6; k++)
                dout((k < 5) ? 12'(k) * 12'h111 : 12'(1 - m) * 12'h111);
        end
        wr(8'h0D, 8'h00);
        print_verdict();
    end
endmodule
